// file: common/buck_ctl_pkg.sv
// Shared constants and carriers for the buck mode and fault control.
// Assumes one 25 MHz clock; all inputs synchronous to it.
package buck_ctl_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned NUM_RAILS = 3;
    localparam logic [3:0] NB_CONSEC_CYCLES = 4'h8;
    localparam int unsigned UV_TIME_US = 1000;
    localparam int unsigned UV_CYCLES = (UV_TIME_US * (CLK_HZ / 1000000));
    localparam int unsigned OFF_WAIT_CYCLES = 1;
    localparam logic [1:0] WINDOW_NORMAL = 2'h0;
    localparam logic [1:0] WINDOW_RAISED = 2'h1;
    localparam int unsigned UV_CNT_W = 16;
    localparam int unsigned RAIL_NB = 2;

    typedef struct packed {
        logic high_side;
        logic low_side;
        logic enable;
    } gate_cmd_t;

    typedef struct packed {
        logic pwm;
        logic switch_node_pos;
        logic high_below_1v;
        logic low_below_1v;
        logic cycle_start;
    } rail_sense_t;

    typedef struct packed {
        logic high_output;
        logic low_output;
        logic excess_current;
    } fault_in_t;
endpackage

// file: core/rail_gate_drive.sv
// One rail's gate interlock and light-load emulation sequencer.
// Assumes comparator inputs are synchronous to sys_clk_i.
module rail_gate_drive
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire buck_ctl_pkg::rail_sense_t sense_i,
    input wire logic emulation_en_i,
    input wire logic is_northbridge_i,
    input wire logic drive_off_i,
    output buck_ctl_pkg::gate_cmd_t gate_o,
    output logic skip_mode_o,
    output logic [1:0] window_sel_o
);
    import buck_ctl_pkg::*;

    logic [3:0] pos_count;
    logic pos_seen;
    logic high_req;
    logic low_req;
    logic skip_now;

    assign high_req = sense_i.pwm;
    assign low_req = !sense_i.pwm && !(skip_mode_o && sense_i.switch_node_pos);

    // RL2 Cross-conduction interlock
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            gate_o <= '0;
        else if (drive_off_i)
            gate_o <= '0;
        else
        begin
            gate_o.enable <= 1'b1;
            gate_o.high_side <= high_req && !gate_o.low_side && sense_i.low_below_1v;
            // RL9 Low side off when node positive
            gate_o.low_side <= low_req && !gate_o.high_side && sense_i.high_below_1v
                && !(emulation_en_i && sense_i.switch_node_pos);
        end
    end

    // RL5 Direction sampled while low side on
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pos_seen <= 1'b0;
        else if (sense_i.cycle_start)
            pos_seen <= 1'b0;
        else if (gate_o.low_side && sense_i.switch_node_pos)
            pos_seen <= 1'b1;
    end

    // RL7 Eight consecutive cycles for northbridge
    // RL8 Counter clears on miss or emulation off
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pos_count <= '0;
        else if (!emulation_en_i)
            pos_count <= '0;
        // Exit restarts the run so skip cannot re-enter next clock
        else if (skip_mode_o && gate_o.low_side && !sense_i.switch_node_pos && sense_i.cycle_start)
            pos_count <= '0;
        else if (sense_i.cycle_start)
        begin
            if (!pos_seen)
                pos_count <= '0;
            else if (pos_count != NB_CONSEC_CYCLES)
                pos_count <= pos_count + 4'h1;
        end
    end

    // RL6 Core enters skip on first positive node
    assign skip_now = is_northbridge_i ? (pos_count == NB_CONSEC_CYCLES) : pos_seen;

    // RL10 Back to continuous after negative node
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            skip_mode_o <= 1'b0;
        else if (!emulation_en_i)
            skip_mode_o <= 1'b0;
        else if (gate_o.low_side && !sense_i.switch_node_pos && sense_i.cycle_start)
            skip_mode_o <= 1'b0;
        else if (skip_now)
            skip_mode_o <= 1'b1;
    end

    // RL11 Window raised on northbridge skip
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            window_sel_o <= WINDOW_NORMAL;
        else
            window_sel_o <= (is_northbridge_i && skip_mode_o) ? WINDOW_RAISED : WINDOW_NORMAL;
    end

    // RL7 Northbridge never skips before eight cycles
    property p_nb_wait;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (is_northbridge_i && $rose(skip_mode_o)) |-> $past(pos_count) == NB_CONSEC_CYCLES;
    endproperty
    a_nb_wait: assert property (p_nb_wait) else $error("nb skip early"); // RL7

    property p_no_overlap;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !(gate_o.high_side && gate_o.low_side);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gate overlap"); // RL2

    property p_count_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !emulation_en_i |=> pos_count == 4'h0;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared"); // RL8

    property p_low_off;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (emulation_en_i && sense_i.switch_node_pos) |=> !gate_o.low_side;
    endproperty
    a_low_off: assert property (p_low_off) else $error("low side on"); // RL9

    property p_window;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (is_northbridge_i && skip_mode_o) |=> window_sel_o == WINDOW_RAISED;
    endproperty
    a_window: assert property (p_window) else $error("window not raised"); // RL11

    property p_force_ccm;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !emulation_en_i |=> !skip_mode_o;
    endproperty
    a_force_ccm: assert property (p_force_ccm) else $error("skip in ccm"); // RL3
endmodule // rail_gate_drive

// file: core/buck_mode_fault_control.sv
// Mode selection, phase shedding, fault latch and power-good for three rails.
// Assumes rail 0/1 are core, rail 2 northbridge; fault flags synchronous.
// Functional notes
// RL1 - Grounded offset resistor selects serial VID with droop
// RL2 - Gate turns on only after opposite below 1V
// RL3 - Request high forces continuous on all rails
// RL4 - Dual-plane request low enables emulation everywhere
// RL5 - Sample switch node while low side conducts
// RL6 - Core skips on first positive switch node
// RL7 - Northbridge skips after eight consecutive positive cycles
// RL8 - Northbridge counter clears on miss or disable
// RL9 - Low side off when switch node positive
// RL10 - Return to continuous after negative switch node
// RL11 - Northbridge skip raises window one third
// RL12 - Uniplane sheds one phase when request low
// RL13 - Power-good low through shutdown and soft-start
// RL14 - Power-good low on faults, reset, disable
// RL15 - Faults latch off until enable toggled
// RL16 - Outside party toggles enable after high fault
// RL17 - Excess current tri-states drivers, no restart
// RL18 - Low output for 1ms latches fault
module buck_mode_fault_control
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic power_save_request_n_i,
    input wire logic uniplane_i,
    input wire logic offset_set_pin_grounded_i,
    input wire logic soft_start_done_i,
    input wire logic outputs_in_limits_i,
    input wire buck_ctl_pkg::fault_in_t fault_i,
    input wire buck_ctl_pkg::rail_sense_t [buck_ctl_pkg::NUM_RAILS-1:0] sense_i,
    output buck_ctl_pkg::gate_cmd_t [buck_ctl_pkg::NUM_RAILS-1:0] gate_o,
    output logic [buck_ctl_pkg::NUM_RAILS-1:0] skip_mode_o,
    output logic [1:0] nb_window_sel_o,
    output logic serial_vid_mode_o,
    output logic droop_enable_o,
    output logic phase_shed_o,
    output logic fault_latched_o,
    output logic power_good_out_o,
    output logic power_good_out_oe_o
);
    import buck_ctl_pkg::*;

    typedef enum logic [1:0] {ST_OFF, ST_SOFT_START, ST_RUN, ST_FAULT} ctl_state_t;

    ctl_state_t state;
    logic [UV_CNT_W-1:0] uv_count;
    logic uv_fault;
    logic any_fault;
    logic emulation_en;
    logic drive_off;
    logic [1:0] unused_window [NUM_RAILS-1:0];

    // RL18 Low output must persist 1ms
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            uv_count <= '0;
        else if (!fault_i.low_output || state != ST_RUN)
            uv_count <= '0;
        else if (uv_count != UV_CNT_W'(UV_CYCLES))
            uv_count <= uv_count + 1'b1;
    end
    assign uv_fault = (uv_count == UV_CNT_W'(UV_CYCLES));
    assign any_fault = fault_i.high_output || fault_i.excess_current || uv_fault;

    // RL15 Latch off until enable drops
    // RL16 Only enable low or reset clears a latched fault
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state <= ST_OFF;
        else if (!enable_i)
            state <= ST_OFF;
        else
        begin
            case (state)
                ST_OFF:
                    state <= ST_SOFT_START;
                ST_SOFT_START:
                    if (any_fault)
                        state <= ST_FAULT;
                    else if (soft_start_done_i)
                        state <= ST_RUN;
                ST_RUN:
                    if (any_fault)
                        state <= ST_FAULT;
                ST_FAULT:
                    state <= ST_FAULT;
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // RL17 All drivers tri-stated in fault
    assign drive_off = (state == ST_FAULT) || (state == ST_OFF);
    assign fault_latched_o = (state == ST_FAULT);

    // RL3 Request high forces continuous
    // RL4 Request low enables emulation
    assign emulation_en = !power_save_request_n_i && (state == ST_RUN);

    // RL1 Offset pin strap
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            serial_vid_mode_o <= 1'b0;
            droop_enable_o <= 1'b0;
        end
        else if (state == ST_OFF)
        begin
            serial_vid_mode_o <= offset_set_pin_grounded_i;
            droop_enable_o <= offset_set_pin_grounded_i;
        end
    end

    // RL12 Shed second core phase in uniplane
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            phase_shed_o <= 1'b0;
        else
            phase_shed_o <= uniplane_i && !power_save_request_n_i;
    end

    genvar r;
    generate
        for (r = 0; r < NUM_RAILS; r++)
        begin : g_rail
            logic [1:0] win;
            rail_gate_drive u_rail
            (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .sense_i(sense_i[r]),
                .emulation_en_i(emulation_en),
                .is_northbridge_i(r == RAIL_NB),
                // Shed phase stays off rather than idling switched
                .drive_off_i(drive_off || (r == 1 && phase_shed_o)),
                .gate_o(gate_o[r]),
                .skip_mode_o(skip_mode_o[r]),
                .window_sel_o(win)
            );
            if (r == RAIL_NB)
            begin : g_nb
                assign nb_window_sel_o = win;
            end
            assign unused_window[r] = win;
        end
    endgenerate

    // RL13 Low until soft-start done and in limits
    // RL14 Low on faults, reset and disable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            power_good_out_oe_o <= 1'b1;
        else
            power_good_out_oe_o <= !(state == ST_RUN && outputs_in_limits_i && !any_fault
                && enable_i);
    end
    assign power_good_out_o = 1'b0;

    property p_pg_fault;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        fault_latched_o |=> power_good_out_oe_o;
    endproperty
    a_pg_fault: assert property (p_pg_fault) else $error("pg released in fault"); // RL14

    sequence s_fault_hit;
        enable_i && (state == ST_RUN) && fault_i.excess_current;
    endsequence
    property p_oc_latch;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        s_fault_hit |=> fault_latched_o ##1 (gate_o[0] == '0 && gate_o[2] == '0);
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("no latch on oc"); // RL17

    property p_stay_latched;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (fault_latched_o && enable_i) |=> fault_latched_o;
    endproperty
    a_stay_latched: assert property (p_stay_latched) else $error("fault cleared"); // RL15

    property p_pg_softstart;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == ST_SOFT_START) |=> power_good_out_oe_o;
    endproperty
    a_pg_softstart: assert property (p_pg_softstart) else $error("pg in soft-start"); // RL13

    property p_shed;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (uniplane_i && !power_save_request_n_i) [*2] |-> phase_shed_o;
    endproperty
    a_shed: assert property (p_shed) else $error("phase not shed"); // RL12
endmodule // buck_mode_fault_control

// file: test/power_stage_model.sv
// Behavioural power stage: PWM timing, gate comparators, switch node.
// Assumes gate commands come from the controller on the same clock.
module power_stage_model
#(
    parameter int PERIOD = 8
)
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire buck_ctl_pkg::gate_cmd_t [buck_ctl_pkg::NUM_RAILS-1:0] gate_i,
    input wire logic [buck_ctl_pkg::NUM_RAILS-1:0] node_pos_i,
    output buck_ctl_pkg::rail_sense_t [buck_ctl_pkg::NUM_RAILS-1:0] sense_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import buck_ctl_pkg::*;
    int cnt;
    logic [NUM_RAILS-1:0] hb;
    logic [NUM_RAILS-1:0] lb;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt <= 0;
        else
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hb <= '1;
            lb <= '1;
        end
        else
        begin
            for (int r = 0; r < NUM_RAILS; r++)
            begin
                hb[r] <= !gate_i[r].high_side;
                lb[r] <= !gate_i[r].low_side;
            end
        end
    end
    always_comb
    begin
        for (int r = 0; r < NUM_RAILS; r++)
        begin
            sense_o[r].pwm = (cnt < PERIOD / 2);
            sense_o[r].cycle_start = (cnt == 0);
            sense_o[r].high_below_1v = hb[r];
            sense_o[r].low_below_1v = lb[r];
            // Dead time: body diode carries forward current, node negative
            sense_o[r].switch_node_pos = gate_i[r].low_side ? node_pos_i[r] : gate_i[r].high_side;
        end
    end
endmodule // power_stage_model

// file: test/test_buck_mode_fault_control.sv
// Self-checking bench for the buck mode and fault control.
// Assumes the power stage model closes the loop on all rails.
module test_buck_mode_fault_control;
    timeunit 1ns;
    timeprecision 100ps;
    import buck_ctl_pkg::*;
    localparam int P = 8;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic enable = 1'b0;
    logic psr_n = 1'b1;
    logic uniplane = 1'b0;
    logic ofs_gnd = 1'b1;
    logic ss_done = 1'b0;
    logic in_limits = 1'b1;
    logic [NUM_RAILS-1:0] node_pos = '0;
    fault_in_t fault = '0;
    rail_sense_t [NUM_RAILS-1:0] sense;
    gate_cmd_t [NUM_RAILS-1:0] gate;
    logic [NUM_RAILS-1:0] skip;
    logic [1:0] nb_window;
    logic svid, droop, shed, flt, pg, pg_oe, prev_high, prev_lb;
    int num_errors = 0;
    int check_count = 0;
    always #20 sys_clk = ~sys_clk;
    buck_mode_fault_control i_dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .enable_i(enable), .power_save_request_n_i(psr_n), .uniplane_i(uniplane),
        .offset_set_pin_grounded_i(ofs_gnd), .soft_start_done_i(ss_done),
        .outputs_in_limits_i(in_limits), .fault_i(fault), .sense_i(sense),
        .gate_o(gate), .skip_mode_o(skip), .nb_window_sel_o(nb_window),
        .serial_vid_mode_o(svid), .droop_enable_o(droop), .phase_shed_o(shed),
        .fault_latched_o(flt), .power_good_out_o(pg), .power_good_out_oe_o(pg_oe));
    power_stage_model #(.PERIOD(P)) i_stage (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .gate_i(gate), .node_pos_i(node_pos), .sense_o(sense));
    function automatic logic pick(input int k);
        case (k)
            0: return pg_oe;
            1: return skip[0];
            2: return skip[2];
            3: return shed;
            4: return flt;
            5: return (nb_window === WINDOW_RAISED);
            6: return gate[0].high_side;
            7: return gate[0].enable;
            8: return svid;
            default: return droop;
        endcase
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_val(input string name, input int k, input logic v, input int lim);
        int i;
        i = 0;
        while (pick(k) !== v && i < lim)
        begin
            step(1);
            i++;
        end
        check(name, v, pick(k));
        if (pick(k) !== v)
            give_verdict();
    endtask
    task automatic hold_val(input string name, input int k, input logic v, input int n);
        repeat (n)
        begin
            step(1);
            check(name, v, pick(k));
        end
    endtask
    // Low side must read below 1V before the high side rises
    always @(negedge sys_clk)
    begin
        if (!sys_rst && gate[0].high_side === 1'b1 && prev_high === 1'b0)
            check("high_side_turn_on", 1'b1, prev_lb);
        prev_high = gate[0].high_side;
        prev_lb = sense[0].low_below_1v;
    end
    initial
    begin
        step(3);
        check("pg_oe_reset", 1'b1, pg_oe);
        check("gate_enable_reset", 1'b0, gate[0].enable);
        sys_rst = 1'b0;
        step(2);
        check("serial_vid_mode", 1'b1, svid);
        check("droop_enable", 1'b1, droop);
        enable = 1'b1;
        hold_val("pg_oe_soft_start", 0, 1'b1, 10);
        ss_done = 1'b1;
        wait_val("pg_oe_run", 0, 1'b0, 5);
        check("pg_data_low", 1'b0, pg);
        node_pos = 3'h7;
        wait_val("high_side_on", 6, 1'b1, P);
        hold_val("core_skip_forced", 1, 1'b0, 4 * P);
        check("nb_skip_forced", 1'b0, skip[2]);
        psr_n = 1'b0;
        wait_val("core_skip", 1, 1'b1, 3 * P);
        check("nb_skip_early", 1'b0, skip[2]);
        wait_val("nb_skip", 2, 1'b1, 9 * P);
        wait_val("nb_window", 5, 1'b1, 3);
        node_pos[2] = 1'b0;
        wait_val("nb_skip_exit", 2, 1'b0, 3 * P);
        step(P);
        node_pos[2] = 1'b1;
        hold_val("nb_count_cleared", 2, 1'b0, 6 * P);
        wait_val("nb_skip_again", 2, 1'b1, 6 * P);
        node_pos[0] = 1'b0;
        wait_val("core_skip_exit", 1, 1'b0, 3 * P);
        uniplane = 1'b1;
        wait_val("phase_shed", 3, 1'b1, 3);
        psr_n = 1'b1;
        wait_val("phase_full", 3, 1'b0, 3);
        wait_val("nb_skip_off", 2, 1'b0, 3);
        wait_val("nb_window_normal", 5, 1'b0, 3);
        fault.excess_current = 1'b1;
        wait_val("fault_latch", 4, 1'b1, 3);
        wait_val("pg_oe_fault", 0, 1'b1, 4);
        wait_val("tri_state", 7, 1'b0, 4);
        fault.excess_current = 1'b0;
        hold_val("no_restart", 4, 1'b1, 20);
        enable = 1'b0;
        wait_val("fault_clear", 4, 1'b0, 3);
        check("pg_oe_disabled", 1'b1, pg_oe);
        enable = 1'b1;
        wait_val("restart", 0, 1'b0, 8);
        fault.high_output = 1'b1;
        wait_val("high_fault", 4, 1'b1, 3);
        fault.high_output = 1'b0;
        enable = 1'b0;
        ofs_gnd = 1'b0;
        step(2);
        check("serial_vid_off", 1'b0, svid);
        check("droop_off", 1'b0, droop);
        ofs_gnd = 1'b1;
        enable = 1'b1;
        wait_val("restart_high", 0, 1'b0, 8);
        check("serial_vid_on", 1'b1, svid);
        fault.low_output = 1'b1;
        step(UV_CYCLES - 5);
        check("low_fault_early", 1'b0, flt);
        wait_val("low_fault", 4, 1'b1, 10);
        check("pg_oe_low_fault", 1'b1, pg_oe);
        give_verdict();
    end
endmodule // test_buck_mode_fault_control
